/* design/slcd_defines.vh */
// Shared constants for the serial LCD segment latch
`ifndef SLCD_DEFINES_VH
`define SLCD_DEFINES_VH
`define SLCD_WIDE_BITS    128
`define SLCD_NARROW_BITS  48
`define SLCD_FRONTPLANES  32
`define SLCD_BACKPLANES   4
`define SLCD_BYTE_BITS    8
`define SLCD_CNT_W        8
`define SLCD_LATCH_RESET  128'h0
`define SLCD_BYTE_LAST    4'h7
`define SLCD_PIN_IDLE     1'b0
`define SLCD_EN_IDLE      1'b1
`endif

/* design/slcd_latch.v */
// Serial shift register and output latch for an LCD segment driver
// How it works
// - Wide mode stores 128 bits, 32x4 segments
// - Auto latch after 128 received bits in wide mode, 48 in narrow mode
// - Enable input latches data at any time in wide mode
// - Ack mode drives ninth-slot acknowledge
// - No-ack mode: bits back to back
// - Enable floating or high still works
// - Shift register separate from displayed latch
// - Narrow mode: 48 bits, 6 digits
// - Narrow mode ignores enable; shares the serial clock with wide mode
`timescale 1ns/1ps
`include "slcd_defines.vh"
module slcd_latch
#(
   parameter WIDE_BITS   = `SLCD_WIDE_BITS,
   parameter NARROW_BITS = `SLCD_NARROW_BITS,
   parameter CNT_W       = `SLCD_CNT_W
)
(
   core_clk,
   arst_n,
   ce,
   ser_clk,
   ser_data_i,
   ser_data_o,
   ser_data_oe,
   latch_en_n,
   ack_mode,
   narrow_mode,
   seg_out,
   latch_pulse
);
   input  wire                 core_clk;
   input  wire                 arst_n;
   input  wire                 ce;
   input  wire                 ser_clk;
   input  wire                 ser_data_i;
   output reg                  ser_data_o;
   output reg                  ser_data_oe;
   input  wire                 latch_en_n;
   input  wire                 ack_mode;
   input  wire                 narrow_mode;
   output reg  [WIDE_BITS-1:0] seg_out;
   output reg                  latch_pulse;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   wire clk_s;
   wire dat_s;
   wire en_n_s;

   slcd_sync #(.RESET_VAL(1'b0)) u_clk (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .ce       (ce),
      .pin_in   (ser_clk),
      .pin_sync (clk_s)
   );
   slcd_sync #(.RESET_VAL(1'b0)) u_dat (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .ce       (ce),
      .pin_in   (ser_data_i),
      .pin_sync (dat_s)
   );
   // Floating enable reads high, so idle is inactive
   slcd_sync #(.RESET_VAL(1'b1)) u_en (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .ce       (ce),
      .pin_in   (latch_en_n),
      .pin_sync (en_n_s)
   );
   // Straps are pins too; they settle two clocks after reset is released
   wire ack_s;
   wire narrow_s;

   slcd_sync #(.RESET_VAL(`SLCD_PIN_IDLE)) u_ack (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .ce       (ce),
      .pin_in   (ack_mode),
      .pin_sync (ack_s)
   );
   slcd_sync #(.RESET_VAL(`SLCD_PIN_IDLE)) u_nar (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .ce       (ce),
      .pin_in   (narrow_mode),
      .pin_sync (narrow_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // Edge detection on synchronised pins
   reg clk_d;
   reg en_n_d;
   wire clk_rise = clk_s & ~clk_d;
   wire clk_fall = ~clk_s & clk_d;
   // Narrow mode has no enable pin at all
   wire en_fall  = ~en_n_s & en_n_d & ~narrow_s;

   ////////////////////////////////////////////////////////////////////////
   // Shift, count and latch
   reg  [WIDE_BITS-1:0] shift;
   reg  [CNT_W-1:0]     bit_cnt;
   reg  [3:0]           byte_bit;
   reg                  ack_slot;

   wire [CNT_W-1:0] frame_bits = narrow_s ? NARROW_BITS[CNT_W-1:0]
                                          : WIDE_BITS[CNT_W-1:0];
   wire             data_edge  = clk_rise & ~ack_slot;
   wire [CNT_W-1:0] next_cnt   = bit_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
   wire             auto_latch = data_edge & (next_cnt == frame_bits);
   wire [WIDE_BITS-1:0] next_shift = {shift[WIDE_BITS-2:0], dat_s};
   wire             ack_edge   = clk_rise & ack_slot;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   reg  [3:0]           next_byte_bit;
   reg                  next_ack_slot;
   reg  [CNT_W-1:0]     next_bit_cnt;
   reg  [WIDE_BITS-1:0] next_seg;
   reg                  next_pulse;
   reg                  next_oe;

   // Byte position and acknowledge slot tracking
   always @*
   begin
      next_byte_bit = byte_bit;
      next_ack_slot = ack_slot;
      if (data_edge)
      begin
         if (byte_bit == `SLCD_BYTE_LAST)
         begin
            next_byte_bit = 4'h0;
            // Only the acknowledging option reserves a ninth clock
            next_ack_slot = ack_s;
         end
         else
         begin
            next_byte_bit = byte_bit + 4'h1;
         end
      end
      else if (ack_edge)
      begin
         next_ack_slot = 1'b0;
      end
      // Enable latch restarts byte framing unless auto latch wins
      if (en_fall && !auto_latch)
      begin
         next_byte_bit = 4'h0;
      end
   end

   // Auto latch has priority over a coincident enable edge
   always @*
   begin
      next_seg     = seg_out;
      next_pulse   = 1'b0;
      next_bit_cnt = bit_cnt;
      if (auto_latch)
      begin
         // Narrow frame sits in the low bits
         next_seg     = next_shift;
         next_pulse   = 1'b1;
         next_bit_cnt = {CNT_W{1'b0}};
      end
      else if (en_fall)
      begin
         next_seg     = shift;
         next_pulse   = 1'b1;
         next_bit_cnt = {CNT_W{1'b0}};
      end
      else if (data_edge)
      begin
         next_bit_cnt = next_cnt;
      end
   end

   // Ack drive moves only while the clock is low, never mid-bit
   always @*
   begin
      next_oe = ser_data_oe;
      if (clk_fall)
      begin
         next_oe = ack_slot;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Edge history
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         clk_d  <= `SLCD_PIN_IDLE;
         en_n_d <= `SLCD_EN_IDLE;
      end
      else if (ce)
      begin
         clk_d  <= clk_s;
         en_n_d <= en_n_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shift register and framing
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         shift    <= `SLCD_LATCH_RESET;
         byte_bit <= 4'h0;
         ack_slot <= 1'b0;
         bit_cnt  <= {CNT_W{1'b0}};
      end
      else if (ce)
      begin
         if (data_edge)
         begin
            shift <= next_shift;
         end
         byte_bit <= next_byte_bit;
         ack_slot <= next_ack_slot;
         bit_cnt  <= next_bit_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Displayed latch; shifting never reaches it directly
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         seg_out     <= `SLCD_LATCH_RESET;
         latch_pulse <= 1'b0;
      end
      else if (ce)
      begin
         seg_out     <= next_seg;
         latch_pulse <= next_pulse;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Open-drain style: value stays low, the enable does the work
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ser_data_o  <= 1'b0;
         ser_data_oe <= 1'b0;
      end
      else if (ce)
      begin
         ser_data_o  <= 1'b0;
         ser_data_oe <= next_oe;
      end
   end
endmodule // slcd_latch

/* design/slcd_sync.v */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module slcd_sync
#(
   parameter RESET_VAL = 1'b0
)
(
   core_clk,
   arst_n,
   ce,
   pin_in,
   pin_sync
);
   input  wire core_clk;
   input  wire arst_n;
   input  wire ce;
   input  wire pin_in;
   output wire pin_sync;

   reg stage1;
   reg stage2;

   // First stage feeds only the second
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stage1 <= RESET_VAL;
         stage2 <= RESET_VAL;
      end
      else if (ce)
      begin
         stage1 <= pin_in;
         stage2 <= stage1;
      end
   end

   assign pin_sync = stage2;
endmodule // slcd_sync

/* test/slcd_host.sv */
// Host model driving the serial link
`timescale 1ns/1ps
module slcd_host
(
   input wire  core_clk,
   input wire  sda,
   input wire  ack_mode,
   output reg  ser_clk,
   output reg  host_d,
   output reg  host_oe,
   output integer acks
);
   initial {ser_clk, host_d, host_oe, acks} = {3'h1, 32'h0};
   // Clock stands low between bits
   task automatic slot(input logic b);
      host_d <= b;
      @(posedge core_clk) ser_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      if (!host_oe && sda === 1'b0) acks = acks + 1;
      ser_clk <= 1'b0;
      host_d <= 1'b0;
      host_oe <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic send(input logic [127:0] v, input integer n);
      for (int i = n - 1; i >= 0; i--)
      begin
         slot(v[i]);
         if (ack_mode && i % 8 == 0)
         begin
            host_oe <= 1'b0;
            slot(1'b1);
         end
      end
   endtask
endmodule // slcd_host

/* test/slcd_latch_sva.sv */
// Checker for the segment latch
`timescale 1ns/1ps
module slcd_latch_sva
#(parameter WIDE_BITS = 128)
(
   input wire                 core_clk,
   input wire                 arst_n,
   input wire                 ser_data_o,
   input wire                 ser_data_oe,
   input wire                 latch_en_n,
   input wire                 ack_mode,
   input wire                 narrow_mode,
   input wire [WIDE_BITS-1:0] seg_out,
   input wire                 latch_pulse
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   chk_seg_held: assert property ($changed(seg_out) |-> latch_pulse) else $error("seg moved");
   chk_pulse_gap: assert property (latch_pulse |=> !latch_pulse[*3]) else $error("pulse");
   chk_ack_low: assert property (ser_data_oe |-> !ser_data_o && ack_mode) else $error("ack");
   chk_no_ack: assert property (!ack_mode |-> !ser_data_oe) else $error("no ack");
   chk_oe_span: assert property ($rose(ser_data_oe) |-> ser_data_oe[*3]) else $error("oe");
   chk_oe_end: assert property (ser_data_oe[*8] |-> ##[1:2] !ser_data_oe) else $error("oe end");
   chk_en_latch: assert property ($fell(latch_en_n) && !narrow_mode |-> ##[2:6] latch_pulse)
      else $error("en");
   chk_narrow_en: assert property (narrow_mode && $fell(latch_en_n) |-> !latch_pulse[*6])
      else $error("narrow en");
endmodule // slcd_latch_sva

/* test/slcd_latch_tb_top.sv */
// Bench for the segment latch
`timescale 1ns/1ps
module slcd_latch_tb_top;
   reg           core_clk = 0, arst_n = 0, latch_en_n = 1, ack_mode = 0, narrow_mode = 0;
   wire          ser_clk, host_d, host_oe, ser_data_o, ser_data_oe, latch_pulse;
   wire [127:0]  seg_out;
   wire          sda = ser_data_oe ? ser_data_o : (host_oe ? host_d : 1'b1);
   integer       acks, mismatches = 0, n_checks = 0, seed = 64776;
   logic [127:0] q[$], m = '1, a, b;
   always #50 core_clk = ~core_clk;
   slcd_latch slcd_latch_inst (.core_clk(core_clk), .arst_n(arst_n), .ce(1'b1), .ser_clk(ser_clk),
      .ser_data_i(sda), .ser_data_o(ser_data_o), .ser_data_oe(ser_data_oe), .latch_en_n(latch_en_n),
      .ack_mode(ack_mode), .narrow_mode(narrow_mode), .seg_out(seg_out), .latch_pulse(latch_pulse));
   slcd_host slcd_host_inst (.core_clk(core_clk), .sda(sda), .ack_mode(ack_mode), .ser_clk(ser_clk),
      .host_d(host_d), .host_oe(host_oe), .acks(acks));
   ////////////////////////////////////////////////////////////
   task check(input string what, input logic [127:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin mismatches++; $display("mismatch %s exp %h seen %h", what, exp, seen); end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Straps change only under reset
   task restart(input logic am, nm);
      @(posedge core_clk) {arst_n, ack_mode, narrow_mode} <= {1'b0, am, nm};
      repeat (16) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask
   always @(posedge core_clk) if (latch_pulse === 1'b1) check("seg", seg_out & m, q.size() ? q.pop_front() : 'x);
   initial begin #2000000 mismatches++; conclude; end
   initial begin
      restart(0, 0);
      a = {$random(seed), $random(seed), $random(seed), $random(seed)};
      b = {$random(seed), $random(seed), $random(seed), $random(seed)};
      q.push_back(a); slcd_host_inst.send(a, 128);
      q.push_back(b); slcd_host_inst.send(b, 128);
      slcd_host_inst.send(a, 40);
      q.push_back({b[87:0], a[39:0]});
      latch_en_n <= 1'b0;
      repeat (8) @(posedge core_clk);
      latch_en_n <= 1'b1;
      q.push_back(b); slcd_host_inst.send(b, 128);
      restart(1, 0);
      q.push_back(a); slcd_host_inst.send(a, 128);
      check("acks", 128'(acks), 128'h10);
      restart(0, 1);
      m = 128'hFFFFFFFFFFFF;
      q.push_back(b & m);
      latch_en_n <= 1'b0;
      slcd_host_inst.send(b, 48);
      latch_en_n <= 1'b1;
      repeat (20) @(posedge core_clk);
      check("queue", 128'(q.size()), 128'h0);
      conclude;
   end
endmodule // slcd_latch_tb_top
bind slcd_latch slcd_latch_sva #(.WIDE_BITS(WIDE_BITS)) slcd_latch_sva_inst (.core_clk(core_clk), .arst_n(arst_n),
   .ser_data_o(ser_data_o), .ser_data_oe(ser_data_oe), .latch_en_n(latch_en_n), .ack_mode(ack_mode),
   .narrow_mode(narrow_mode), .seg_out(seg_out), .latch_pulse(latch_pulse));
